//--- slef_checker.sv
// Port assertions for the serial line echo front end
`timescale 1ns/1ps
module slef_checker
  import slef_pkg::*;
#(
  parameter logic [CNT_W-1:0] BIT_CYC = BIT_CYC_DEF
) (
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             txd,
  input wire logic             cmd_valid,
  input wire logic             cmd_ready,
  input wire logic [PTR_W-1:0] cmd_len,
  input wire logic             exec_done,
  input wire logic             rsp_valid,
  input wire logic             rsp_ready
);
  logic [19:0] low_run;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////
  // Length of the current low stretch on txd
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) low_run <= 20'h0;
    else low_run <= txd ? 20'h0 : low_run + 20'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Line hand-off to the parser and closing of replies after finish
  a_valid_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid)
    else $error("line offer withdrawn early");
  a_valid_drop: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
    else $error("line offer kept after acceptance");
  a_len_steady: assert property (cmd_valid |=> $stable(cmd_len))
    else $error("line length moved while offered");
  a_len_after: assert property ($fell(cmd_valid) |-> $stable(cmd_len))
    else $error("line length moved at acceptance");
  a_len_limit: assert property (cmd_len <= 7'h40)
    else $error("line length beyond buffer");
  a_rsp_close: assert property (exec_done && !cmd_valid |=> !rsp_ready)
    else $error("replies still taken after finish");
  // Serial frame shape on txd
  a_bit_whole: assert property ($rose(txd) |-> low_run % BIT_CYC == 0)
    else $error("low stretch not whole bits");
  a_low_max: assert property (low_run <= 9 * BIT_CYC)
    else $error("low stretch longer than a frame");
  a_idle_reset: assert property ($rose(rst_n) |-> txd [*3])
    else $error("txd not idle after reset");

  // Main scenarios reached
  c_accept: cover property (cmd_valid && cmd_ready);
  c_refuse: cover property (rsp_valid && !rsp_ready);
  c_full: cover property (cmd_len == 7'h40);
  c_done: cover property (exec_done && !cmd_valid);
endmodule

bind slef_top slef_checker #(.BIT_CYC(BIT_CYC)) slef_checker_inst (
  .mclk, .rst_n, .txd, .cmd_valid, .cmd_ready, .cmd_len, .exec_done,
  .rsp_valid, .rsp_ready);

//--- slef_fifo.sv
// Transmit queue FIFO with valid/ready on both sides
`timescale 1ns/1ps
module slef_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;
  logic [AW:0]  next_wptr;
  logic [AW:0]  next_rptr;
  logic         push;
  logic         pop;

  ////////////////////////////////////////////////////////////////////////////
  // Full and empty from pointers with wrap bit
  always_comb begin
    out_valid = (wptr != rptr);
    in_ready  = (wptr != {~rptr[AW], rptr[AW-1:0]});
    out_data  = mem[rptr[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
  end

  // Pointer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

endmodule

//--- slef_host.sv
// Host terminal model: sends and collects 8N1 frames
`timescale 1ns/1ps
module slef_host #(
  parameter int BIT_CYC = 16
) (
  input wire logic mclk,
  input wire logic txd,
  output logic     rxd
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  int         bad;

  // One frame, LSB first, at the device's fixed rate
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask

  // Collect frames from txd, checking start and stop levels
  initial begin
    rxd = 1'b1;
    bad = 0;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge mclk);
      if (txd !== 1'b0) bad++;
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk);
        sh[i] = txd;
      end
      repeat (BIT_CYC) @(posedge mclk);
      if (txd !== 1'b1) bad++;
      rx_q.push_back(sh);
    end
  end
endmodule

//--- slef_pkg.sv
// Constants and types shared by the serial line echo front end
// Overview of operation
// (RULE_01) Link runs 9600 baud, 8N1, both directions
// (RULE_02) Rate and frame format are fixed constants
// (RULE_03) Host should match rate and frame format
// (RULE_04) Other characters stored, pointer advanced, echoed
// (RULE_05) Backspace: pointer back, send 08 20 08
// (RULE_06) CR or LF hands line to parser
// (RULE_07) Parser replies are sent back immediately
// (RULE_08) After execution send CR, LF, '>' prompt
// (RULE_09) Host may send a message at any time
// (RULE_10) Echo confirms reception, no hardware handshake
// (RULE_11) Host ends each message with a terminator
// (RULE_12) Host separates one parameter by a space
// (RULE_13) Host starts common commands with asterisk
// (RULE_14) Host may send each command per line
// (RULE_15) Terminator is LF, CR, or CR LF
// (RULE_16) Backspace on empty line keeps pointer zero
// (RULE_17) Full line drops characters until terminator
package slef_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Link timing, fixed at build time
  localparam int CLK_HZ    = 125_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int CNT_W     = 16;
  // Clock cycles per bit, rounded to nearest
  localparam logic [CNT_W-1:0] BIT_CYC_DEF =
    CNT_W'((CLK_HZ + BAUD_RATE / 2) / BAUD_RATE);
  // Bits sent after start: data then stop
  localparam logic [3:0] TX_BITS = 4'(DATA_BITS + STOP_BITS);
  localparam logic [3:0] RX_LAST = 4'(DATA_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // Character codes
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_GT = 8'h3e;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer sizes
  localparam int LINE_DEPTH = 64;
  localparam int ADDR_W     = 6;
  localparam int PTR_W      = 7;
  localparam logic [PTR_W-1:0] PTR_FULL = PTR_W'(LINE_DEPTH);
  localparam int TXQ_DEPTH  = 16;
  localparam int TXQ_W      = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Line editor states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PARSE = 3'h1,
    ST_PR_CR = 3'h3,
    ST_PR_LF = 3'h2,
    ST_PR_GT = 3'h6,
    ST_BS_A  = 3'h4,
    ST_BS_SP = 3'h5,
    ST_BS_B  = 3'h7
  } slef_state_t;

endpackage

//--- slef_top.sv
// Serial line echo front end: receiver, line editor, transmitter
`timescale 1ns/1ps
module slef_top
  import slef_pkg::*;
#(
  parameter logic [CNT_W-1:0] BIT_CYC = BIT_CYC_DEF
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   cmd_valid,
  input  wire logic              cmd_ready,
  output logic [PTR_W-1:0]       cmd_len,
  input  wire logic [ADDR_W-1:0] cmd_rd_addr,
  output logic [7:0]             cmd_rd_data,
  input  wire logic              exec_done,
  input  wire logic              rsp_valid,
  input  wire logic [7:0]        rsp_data,
  output logic                   rsp_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: 8N1 sampled mid-bit, fixed rate
  logic             rx_busy;
  logic [CNT_W-1:0] rx_cnt;
  logic [3:0]       rx_bit;
  logic [7:0]       rx_shift;
  logic             rx_pend;
  logic [7:0]       rx_char;
  logic             next_rx_busy;
  logic [CNT_W-1:0] next_rx_cnt;
  logic [3:0]       next_rx_bit;
  logic [7:0]       next_rx_shift;
  logic             next_rx_pend;
  logic [7:0]       next_rx_char;
  logic             rx_take;

  // Bit timing and capture; a received byte waits in rx_char
  always_comb begin
    next_rx_busy  = rx_busy;
    next_rx_cnt   = rx_cnt;
    next_rx_bit   = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_char  = rx_char;
    next_rx_pend  = rx_pend && !rx_take;
    if (!rx_busy) begin
      if (!rxd) begin // RULE_09
        next_rx_busy = 1'b1;
        next_rx_cnt  = {1'b0, BIT_CYC[CNT_W-1:1]};
        next_rx_bit  = 4'h0;
      end
    end else if (rx_cnt != '0) begin
      next_rx_cnt = rx_cnt - 1'b1;
    end else begin
      next_rx_cnt = BIT_CYC - 1'b1; // RULE_01
      if (rx_bit == 4'h0) begin
        // A start bit that vanished was a glitch
        next_rx_busy = !rxd;
        next_rx_bit  = 4'h1;
      end else if (rx_bit <= RX_LAST) begin
        next_rx_shift = {rxd, rx_shift[7:1]};
        next_rx_bit   = rx_bit + 1'b1;
      end else begin
        next_rx_busy = 1'b0;
        if (rxd) begin // RULE_01
          // New byte wins over the take of the old one
          next_rx_pend = 1'b1;
          next_rx_char = rx_shift;
        end
      end
    end
  end

  // Receiver registers
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_busy  <= 1'b0;
      rx_cnt   <= '0;
      rx_bit   <= 4'h0;
      rx_shift <= 8'h00;
      rx_pend  <= 1'b0;
      rx_char  <= 8'h00;
    end else begin
      rx_busy  <= next_rx_busy;
      rx_cnt   <= next_rx_cnt;
      rx_bit   <= next_rx_bit;
      rx_shift <= next_rx_shift;
      rx_pend  <= next_rx_pend;
      rx_char  <= next_rx_char;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit queue between editor and transmitter
  logic       q_in_valid;
  logic       q_in_ready;
  logic [7:0] q_in_data;
  logic       q_out_valid;
  logic       q_out_ready;
  logic [7:0] q_out_data;

  slef_fifo #(
    .W (TXQ_W),
    .D (TXQ_DEPTH)
  ) u_txq (
    .clk       (mclk),
    .rst_n     (rst_sync_n),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (q_in_data),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: start, 8 data LSB first, 1 stop
  logic             tx_busy;
  logic [CNT_W-1:0] tx_cnt;
  logic [3:0]       tx_bits;
  logic [8:0]       tx_shift;
  logic             tx_line;
  logic             next_tx_busy;
  logic [CNT_W-1:0] next_tx_cnt;
  logic [3:0]       next_tx_bits;
  logic [8:0]       next_tx_shift;
  logic             next_tx_line;

  assign q_out_ready = !tx_busy;
  assign txd         = tx_line;

  // Bit divider gives one enable per bit time
  always_comb begin
    next_tx_busy  = tx_busy;
    next_tx_cnt   = tx_cnt;
    next_tx_bits  = tx_bits;
    next_tx_shift = tx_shift;
    next_tx_line  = tx_line;
    if (!tx_busy) begin
      if (q_out_valid) begin
        next_tx_busy  = 1'b1;
        next_tx_line  = 1'b0;
        next_tx_shift = {1'b1, q_out_data};
        next_tx_bits  = TX_BITS; // RULE_01
        next_tx_cnt   = BIT_CYC - 1'b1; // RULE_02
      end
    end else if (tx_cnt != '0) begin
      next_tx_cnt = tx_cnt - 1'b1;
    end else if (tx_bits != 4'h0) begin
      next_tx_line  = tx_shift[0];
      next_tx_shift = {1'b1, tx_shift[8:1]};
      next_tx_bits  = tx_bits - 1'b1;
      next_tx_cnt   = BIT_CYC - 1'b1;
    end else begin
      next_tx_busy = 1'b0; // Stop bit time has elapsed
    end
  end

  // Transmitter registers; line idles high
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_busy  <= 1'b0;
      tx_cnt   <= '0;
      tx_bits  <= 4'h0;
      tx_shift <= 9'h1ff;
      tx_line  <= 1'b1;
    end else begin
      tx_busy  <= next_tx_busy;
      tx_cnt   <= next_tx_cnt;
      tx_bits  <= next_tx_bits;
      tx_shift <= next_tx_shift;
      tx_line  <= next_tx_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line editor
  logic [7:0]       line_mem [LINE_DEPTH];
  slef_state_t      st;
  slef_state_t      next_st;
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] next_ptr;
  logic             last_cr;
  logic             next_last_cr;
  logic             next_cmd_valid;
  logic             wr_en;

  assign cmd_len = ptr;

  // Character handling, erase sequence, parser hand-off and prompt
  always_comb begin
    next_st        = st;
    next_ptr       = ptr;
    next_last_cr   = last_cr;
    next_cmd_valid = cmd_valid;
    q_in_valid     = 1'b0;
    q_in_data      = 8'h00;
    rx_take        = 1'b0;
    wr_en          = 1'b0;
    rsp_ready      = 1'b0;
    unique case (st)
      ST_IDLE: begin
        if (rx_pend) begin
          if (rx_char == CH_BS) begin
            rx_take      = 1'b1;
            next_last_cr = 1'b0;
            if (ptr != '0) begin // RULE_16
              next_ptr = ptr - 1'b1; // RULE_05
              next_st  = ST_BS_A;
            end
          end else if (rx_char == CH_LF && last_cr) begin
            rx_take      = 1'b1; // RULE_15
            next_last_cr = 1'b0;
          end else if (rx_char == CH_CR || rx_char == CH_LF) begin
            rx_take        = 1'b1;
            next_last_cr   = (rx_char == CH_CR); // RULE_15
            next_cmd_valid = 1'b1; // RULE_06
            next_st        = ST_PARSE;
          end else if (ptr == PTR_FULL) begin
            rx_take      = 1'b1; // RULE_17
            next_last_cr = 1'b0;
          end else begin
            // Echo waits for room in the queue
            q_in_valid = 1'b1; // RULE_10
            q_in_data  = rx_char; // RULE_04
            if (q_in_ready) begin
              rx_take      = 1'b1;
              wr_en        = 1'b1; // RULE_04
              next_ptr     = ptr + 1'b1; // RULE_04
              next_last_cr = 1'b0;
            end
          end
        end
      end
      ST_BS_A: begin
        q_in_valid = 1'b1;
        q_in_data  = CH_BS; // RULE_05
        if (q_in_ready) begin
          next_st = ST_BS_SP;
        end
      end
      ST_BS_SP: begin
        q_in_valid = 1'b1;
        q_in_data  = CH_SP; // RULE_05
        if (q_in_ready) begin
          next_st = ST_BS_B;
        end
      end
      ST_BS_B: begin
        q_in_valid = 1'b1;
        q_in_data  = CH_BS; // RULE_05
        if (q_in_ready) begin
          next_st = ST_IDLE;
        end
      end
      ST_PARSE: begin
        // Replies pass straight to the queue
        q_in_valid = rsp_valid; // RULE_07
        q_in_data  = rsp_data; // RULE_07
        rsp_ready  = q_in_ready; // RULE_07
        if (cmd_valid && cmd_ready) begin
          next_cmd_valid = 1'b0;
        end
        if (exec_done && !cmd_valid) begin
          next_ptr = '0;
          next_st  = ST_PR_CR; // RULE_08
        end
      end
      ST_PR_CR: begin
        q_in_valid = 1'b1;
        q_in_data  = CH_CR; // RULE_08
        if (q_in_ready) begin
          next_st = ST_PR_LF;
        end
      end
      ST_PR_LF: begin
        q_in_valid = 1'b1;
        q_in_data  = CH_LF; // RULE_08
        if (q_in_ready) begin
          next_st = ST_PR_GT;
        end
      end
      ST_PR_GT: begin
        q_in_valid = 1'b1;
        q_in_data  = CH_GT; // RULE_08
        if (q_in_ready) begin
          next_st = ST_IDLE;
        end
      end
    endcase
  end

  // Editor registers
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st        <= ST_IDLE;
      ptr       <= '0;
      last_cr   <= 1'b0;
      cmd_valid <= 1'b0;
    end else begin
      st        <= next_st;
      ptr       <= next_ptr;
      last_cr   <= next_last_cr;
      cmd_valid <= next_cmd_valid;
    end
  end

  // Line buffer write and parser read port
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      line_mem[ptr[ADDR_W-1:0]] <= rx_char; // RULE_04
    end
    cmd_rd_data <= line_mem[cmd_rd_addr];
  end

endmodule

//--- slef_top_bench.sv
// Self-checking bench for the serial line echo front end
`timescale 1ns/1ps
module slef_top_bench
  import slef_pkg::*;
;
  localparam int BC = 16;
  logic              mclk;
  logic              rst_n;
  logic              rxd;
  logic              txd;
  logic              cmd_valid;
  logic              cmd_ready;
  logic [PTR_W-1:0]  cmd_len;
  logic [ADDR_W-1:0] cmd_rd_addr;
  logic [7:0]        cmd_rd_data;
  logic              exec_done;
  logic              rsp_valid;
  logic [7:0]        rsp_data;
  logic              rsp_ready;
  int                n_mismatch;
  int                num_checks;
  int                refused;

  slef_top #(.BIT_CYC(16'(BC))) slef_top_inst (.mclk, .rst_n, .rxd, .txd,
    .cmd_valid, .cmd_ready, .cmd_len, .cmd_rd_addr, .cmd_rd_data,
    .exec_done, .rsp_valid, .rsp_data, .rsp_ready);
  slef_host #(.BIT_CYC(BC)) slef_host_inst (.mclk, .txd, .rxd);

  // Clock source
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Next character returned on txd, bounded wait
  task automatic expect_tx(input logic [7:0] exp);
    for (int t = 0; t < 40 * BC && slef_host_inst.rx_q.size() == 0; t++)
      @(posedge mclk);
    if (slef_host_inst.rx_q.size() == 0) check(8'hxx, exp);
    else check(slef_host_inst.rx_q.pop_front(), exp);
  endtask

  // Parser stand-in: take line, reply n bytes, finish, see prompt
  task automatic parse(input logic [7:0] len, input logic [7:0] c0,
                       input int n);
    for (int t = 0; t < 400 && cmd_valid !== 1'b1; t++) @(negedge mclk);
    check({7'h0, cmd_valid}, 8'h1);
    check({1'b0, cmd_len}, len);
    @(posedge mclk);
    cmd_ready <= 1'b1;
    cmd_rd_addr <= 6'h0;
    @(posedge mclk);
    cmd_ready <= 1'b0;
    @(negedge mclk);
    if (len != 8'h0) check(cmd_rd_data, c0);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rsp_valid <= 1'b1;
      rsp_data <= 8'h30 + 8'(i);
      // Ready is settled after the edge; the next edge takes the byte
      @(negedge mclk);
      for (int t = 0; t < 40 * BC && rsp_ready !== 1'b1; t++) begin
        refused++;
        @(negedge mclk);
      end
    end
    @(posedge mclk);
    rsp_valid <= 1'b0;
    exec_done <= 1'b1;
    @(posedge mclk);
    exec_done <= 1'b0;
    for (int i = 0; i < n; i++) expect_tx(8'h30 + 8'(i));
    expect_tx(CH_CR);
    expect_tx(CH_LF);
    expect_tx(CH_GT);
  endtask

  // Echoed command line with a long reply that fills the queue
  task automatic s_line;
    string s;
    s = "*I 5";
    foreach (s[i]) slef_host_inst.send(s[i]);
    foreach (s[i]) expect_tx(s[i]);
    slef_host_inst.send(CH_CR);
    refused = 0;
    parse(8'h4, 8'h2a, 20);
    check(8'(refused > 0), 8'h1);
  endtask

  // Backspace on empty line, erase sequence, CR LF terminator
  task automatic s_erase;
    slef_host_inst.send(CH_BS);
    slef_host_inst.send(8'h58);
    slef_host_inst.send(8'h59);
    slef_host_inst.send(CH_BS);
    expect_tx(8'h58);
    expect_tx(8'h59);
    expect_tx(CH_BS);
    expect_tx(CH_SP);
    expect_tx(CH_BS);
    slef_host_inst.send(CH_CR);
    slef_host_inst.send(CH_LF);
    parse(8'h1, 8'h58, 0);
    repeat (20 * BC) @(posedge mclk);
    check(8'(slef_host_inst.rx_q.size()), 8'h0);
  endtask

  // Over-long line: the 65th character is dropped unechoed
  task automatic s_full;
    for (int i = 0; i < 65; i++) slef_host_inst.send(8'h21 + 8'(i));
    for (int i = 0; i < 64; i++) expect_tx(8'h21 + 8'(i));
    slef_host_inst.send(CH_LF);
    parse(8'h40, 8'h21, 0);
  endtask

  // Reset, scenarios, verdict
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    rst_n = 1'b0;
    cmd_ready = 1'b0;
    cmd_rd_addr = 6'h0;
    exec_done = 1'b0;
    rsp_valid = 1'b0;
    rsp_data = 8'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    s_line();
    s_erase();
    s_full();
    check(8'(slef_host_inst.bad), 8'h0);
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    finish_test();
  end
endmodule
